// [core/cpfs_clock_pin_select.sv]
`timescale 1ns/10ps
module cpfs_clock_pin_select
  import cpfs_pkg::*;
(
  input  wire logic                    core_clk,             // 100 MHz clock
  input  wire logic                    srst,                 // Power-up reset
  input  wire cpfs_pkg::cpfs_reg_req_t reg_req,              // Register write port
  input  wire logic [7:0]              reg_rd_addr,          // Register read address
  output logic [7:0]                   reg_rdata,            // Read data, one cycle later
  input  wire logic                    pci_clk_gen,          // Internal 33 MHz clock level
  input  wire logic                    pci_stop_n,           // PCI stop pin
  input  wire logic                    pci0_i,               // Shared pin A level
  output logic                         pci0_o,               // Shared pin A drive
  output logic                         pci0_oe,              // Shared pin A enable
  input  wire logic                    pci1_i,               // Shared pin B level
  output logic                         pci1_o,               // Shared pin B drive
  output logic                         pci1_oe,              // Shared pin B enable
  input  wire logic                    pci2_i,               // Trusted strap pin level
  output logic                         pci2_o,               // Trusted strap pin drive
  output logic                         pci2_oe,              // Trusted strap pin enable
  output logic                         pci3_o,               // Plain PCI clock
  input  wire logic                    pci4_i,               // Pair-5 strap pin level
  output logic                         pci4_o,               // Pair-5 strap pin drive
  output logic                         pci4_oe,              // Pair-5 strap pin enable
  input  wire logic                    debug_strap_i,        // Debug strap pin level
  output logic                         free_running_pci_clk, // Free-running drive
  output logic                         free_running_oe,      // Free-running enable
  output logic [CPFS_PAIR_W-1:0]       ref_diff_pair_run,    // Pair run gates 0..4
  output cpfs_pkg::cpfs_straps_t       straps                // Captured straps
);
  import cpfs_pkg::*;

  logic [7:0] out_en_reg;
  logic [7:0] req_cfg_reg;
  logic       req_a_s1_reg;
  logic       clk_request_a_n;
  logic       req_b_s1_reg;
  logic       clk_request_b_n;
  logic       stop_s1_reg;
  logic       stop_s2_reg;
  logic       trust_val;
  logic       trust_done;
  logic       p5_val;
  logic       p5_done;
  logic       dbg_val;
  logic       dbg_done;

  cpfs_strap_latch u_trust (
    .core_clk  (core_clk),
    .srst      (srst),
    .pad_i     (pci2_i),
    .strap_val (trust_val),
    .done      (trust_done)
  );
  cpfs_strap_latch u_pair5 (
    .core_clk  (core_clk),
    .srst      (srst),
    .pad_i     (pci4_i),
    .strap_val (p5_val),
    .done      (p5_done)
  );
  cpfs_strap_latch u_debug (
    .core_clk  (core_clk),
    .srst      (srst),
    .pad_i     (debug_strap_i),
    .strap_val (dbg_val),
    .done      (dbg_done)
  );

  // Register decode
  wire wr_out_en  = reg_req.wr_en && (reg_req.addr == CPFS_OUT_EN_OFS);
  wire wr_req_cfg = reg_req.wr_en && (reg_req.addr == CPFS_REQ_CFG_OFS);
  wire [7:0] rd_mux = (reg_rd_addr == CPFS_OUT_EN_OFS)  ? out_en_reg  :
                      (reg_rd_addr == CPFS_REQ_CFG_OFS) ? req_cfg_reg : 8'h00;

  always_ff @(posedge core_clk) begin
    if (srst) begin
      out_en_reg  <= CPFS_OUT_EN_RST;
      req_cfg_reg <= CPFS_REQ_CFG_RST;
      reg_rdata   <= 8'h00;
    end else begin
      if (wr_out_en) begin
        out_en_reg <= reg_req.wdata;
      end
      if (wr_req_cfg) begin
        req_cfg_reg <= reg_req.wdata;
      end
      reg_rdata <= rd_mux;
    end
  end

  // Pin synchronisers
  always_ff @(posedge core_clk) begin
    req_a_s1_reg    <= pci0_i;
    clk_request_a_n <= req_a_s1_reg;
    req_b_s1_reg    <= pci1_i;
    clk_request_b_n <= req_b_s1_reg;
    stop_s1_reg     <= pci_stop_n;
    stop_s2_reg     <= stop_s1_reg;
  end

  // Pin roles and pair gating
  wire request_a_pin_enable = req_cfg_reg[CPFS_REQ_A_EN_BIT];
  wire request_b_pin_enable = req_cfg_reg[CPFS_REQ_B_EN_BIT];
  // Stop pin exists only when the pair-5 strap chose stop inputs
  wire pci_stopped = !p5_val && p5_done && !stop_s2_reg;
  wire pci_gated   = pci_clk_gen && !pci_stopped;
  wire a_drive = out_en_reg[CPFS_EN_PCI0_BIT] && !request_a_pin_enable;
  wire b_drive = out_en_reg[CPFS_EN_PCI1_BIT] && !request_b_pin_enable;
  // Request held high by the requester stops the steered pair
  wire a_stop  = request_a_pin_enable && clk_request_a_n;
  wire b_stop  = request_b_pin_enable && clk_request_b_n;
  wire a_hi    = req_cfg_reg[CPFS_REQ_A_SEL];
  wire b_hi    = req_cfg_reg[CPFS_REQ_B_SEL];
  wire [CPFS_PAIR_W-1:0] run_next = {
    !(b_stop && b_hi),
    1'b1,
    !(a_stop && a_hi),
    !(b_stop && !b_hi),
    !(a_stop && !a_hi)
  };

  always_ff @(posedge core_clk) begin
    if (srst) begin
      pci0_o               <= 1'b0;
      pci0_oe              <= 1'b0;
      pci1_o               <= 1'b0;
      pci1_oe              <= 1'b0;
      pci2_o               <= 1'b0;
      pci2_oe              <= 1'b0;
      pci3_o               <= 1'b0;
      pci4_o               <= 1'b0;
      pci4_oe              <= 1'b0;
      free_running_pci_clk <= 1'b0;
      free_running_oe      <= 1'b0;
      ref_diff_pair_run    <= '1;
      straps               <= '0;
    end else begin
      pci0_o               <= pci_gated;
      pci0_oe              <= a_drive;
      pci1_o               <= pci_gated;
      pci1_oe              <= b_drive;
      pci2_o               <= pci_gated;
      pci2_oe              <= trust_done;
      pci3_o               <= pci_gated;
      pci4_o               <= pci_gated;
      pci4_oe              <= p5_done;
      free_running_pci_clk <= pci_clk_gen;
      free_running_oe      <= dbg_done;
      ref_diff_pair_run    <= run_next;
      straps               <= '{overclock_locked: trust_val,
                                pair5_outputs:    p5_val,
                                debug_pair_sel:   dbg_val};
    end
  end

  sequence s_released;
    $fell(srst) && !reg_req.wr_en;
  endsequence

  default_drive_a: assert property (@(posedge core_clk)
    s_released |=> pci0_oe)
    else $error("shared pin A not driving after reset");
  role_a_float_a: assert property (@(posedge core_clk) disable iff (srst)
    request_a_pin_enable |=> !pci0_oe)
    else $error("pin A driven in request role");
  en_clear_hiz_a: assert property (@(posedge core_clk) disable iff (srst)
    !out_en_reg[CPFS_EN_PCI0_BIT] |=> !pci0_oe)
    else $error("pin A driven with enable clear");
  role_b_float_a: assert property (@(posedge core_clk) disable iff (srst)
    (request_b_pin_enable || !out_en_reg[CPFS_EN_PCI1_BIT]) |=> !pci1_oe)
    else $error("pin B driven when it should float");
  req_a_gate_a: assert property (@(posedge core_clk) disable iff (srst)
    a_stop |=> (ref_diff_pair_run[0] == $past(a_hi)) && (ref_diff_pair_run[2] == !$past(a_hi)))
    else $error("request A gated wrong pair");
  req_b_gate_a: assert property (@(posedge core_clk) disable iff (srst)
    b_stop |=> (ref_diff_pair_run[1] == $past(b_hi)) && (ref_diff_pair_run[4] == !$past(b_hi)))
    else $error("request B gated wrong pair");
  trust_pin_out_a: assert property (@(posedge core_clk) disable iff (srst)
    $rose(pci2_oe) |-> $past(trust_done))
    else $error("trusted strap pin driven before capture");
  free_run_a: assert property (@(posedge core_clk) disable iff (srst)
    !$past(srst) |-> free_running_pci_clk == $past(pci_clk_gen))
    else $error("free-running clock was gated");
  pair5_nostop_a: assert property (@(posedge core_clk) disable iff (srst)
    (p5_val && pci_clk_gen) |=> pci3_o)
    else $error("stop applied with pair-5 strap set");
  lock_stable_a: assert property (@(posedge core_clk) disable iff (srst)
    ($past(trust_done) && !$past(srst)) |=> $stable(straps.overclock_locked))
    else $error("overclock lock changed after power-up");

  sequence s_stop_held;
    !p5_val && p5_done && !stop_s2_reg;
  endsequence

  trust_drive_a: assert property (@(posedge core_clk) disable iff (srst)
    trust_done |=> pci2_oe)
    else $error("trusted strap pin not driving after capture");
  stop_gate_a: assert property (@(posedge core_clk) disable iff (srst)
    s_stop_held |=> !pci0_o && !pci1_o && !pci2_o && !pci3_o && !pci4_o)
    else $error("PCI clock ran while stop was held");
  req_a_run_a: assert property (@(posedge core_clk) disable iff (srst)
    (request_a_pin_enable && !clk_request_a_n) |=>
      (ref_diff_pair_run[0] && ref_diff_pair_run[2]))
    else $error("pairs of request A stopped while it asks to run");
  req_b_run_a: assert property (@(posedge core_clk) disable iff (srst)
    (request_b_pin_enable && !clk_request_b_n) |=>
      (ref_diff_pair_run[1] && ref_diff_pair_run[4]))
    else $error("pairs of request B stopped while it asks to run");
endmodule : cpfs_clock_pin_select

// [core/cpfs_pkg.sv]
package cpfs_pkg;
  localparam logic [7:0] CPFS_OUT_EN_OFS   = 8'h02;
  localparam logic [7:0] CPFS_REQ_CFG_OFS  = 8'h05;
  localparam logic [7:0] CPFS_OUT_EN_RST   = 8'hFF;
  localparam logic [7:0] CPFS_REQ_CFG_RST  = 8'h00;
  localparam int         CPFS_EN_PCI0_BIT  = 0;
  localparam int         CPFS_EN_PCI1_BIT  = 1;
  localparam int         CPFS_REQ_A_EN_BIT = 7;
  localparam int         CPFS_REQ_A_SEL    = 6;
  localparam int         CPFS_REQ_B_EN_BIT = 5;
  localparam int         CPFS_REQ_B_SEL    = 4;
  localparam int         CPFS_PAIR_W       = 5;

  // Byte-wide register port from the two-wire serial engine
  typedef struct packed {
    logic       wr_en;
    logic [7:0] addr;
    logic [7:0] wdata;
  } cpfs_reg_req_t;

  // Captured power-up straps
  typedef struct packed {
    logic overclock_locked;
    logic pair5_outputs;
    logic debug_pair_sel;
  } cpfs_straps_t;

  typedef enum logic { CPFS_SAMPLING, CPFS_DONE } cpfs_strap_state_t;
endpackage : cpfs_pkg

// [core/cpfs_strap_latch.sv]
`timescale 1ns/10ps
module cpfs_strap_latch
  import cpfs_pkg::*;
(
  input  wire logic core_clk,   // 100 MHz clock
  input  wire logic srst,       // Power-up reset
  input  wire logic pad_i,      // Strap pin level
  output logic      strap_val,  // Captured strap
  output logic      done        // Capture taken, pin may drive
);
  logic              sync1_reg;
  logic              sync2_reg;
  cpfs_strap_state_t state_reg;
  cpfs_strap_state_t state_next;
  logic              val_next;
  logic              settle_reg;

  // Synchroniser runs through reset; capture waits one cycle after release
  // so that sync2 holds a pad sample taken while the pin was floated
  always_ff @(posedge core_clk) begin
    sync1_reg <= pad_i;
    sync2_reg <= sync1_reg;
  end

  always_comb begin
    state_next = state_reg;
    val_next   = strap_val;
    case (state_reg)
      CPFS_SAMPLING: begin
        if (settle_reg) begin
          val_next   = sync2_reg;
          state_next = CPFS_DONE;
        end
      end
      CPFS_DONE: begin
        state_next = CPFS_DONE;
      end
      default: state_next = CPFS_SAMPLING;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      state_reg  <= CPFS_SAMPLING;
      strap_val  <= 1'b0;
      done       <= 1'b0;
      settle_reg <= 1'b0;
    end else begin
      state_reg  <= state_next;
      strap_val  <= val_next;
      done       <= (state_next == CPFS_DONE);
      settle_reg <= 1'b1;
    end
  end

  strap_hold_a: assert property (@(posedge core_clk) disable iff (srst)
    done |=> $stable(strap_val) && done)
    else $error("strap changed after capture");
endmodule : cpfs_strap_latch

// [dv/cpfs_board_model.sv]
`timescale 1ns/10ps
module cpfs_board_model (
  input  wire logic trusted_lvl, // Trusted strap resistor level
  input  wire logic pair5_lvl,   // Pair-5 strap resistor level
  input  wire logic debug_lvl,   // Debug strap resistor level
  input  wire logic pci0_o,   // Pin A drive
  input  wire logic pci0_oe,  // Pin A enable
  input  wire logic pci1_o,   // Pin B drive
  input  wire logic pci1_oe,  // Pin B enable
  input  wire logic pci2_o,   // Trusted pin drive
  input  wire logic pci2_oe,  // Trusted pin enable
  input  wire logic pci4_o,   // Pair-5 pin drive
  input  wire logic pci4_oe,  // Pair-5 pin enable
  input  wire logic f5_o,     // Free-running drive
  input  wire logic f5_oe,    // Free-running enable
  input  wire logic req_a_n,  // Board request A level
  input  wire logic req_b_n,  // Board request B level
  output logic      pci0_i,   // Pin A level
  output logic      pci1_i,   // Pin B level
  output logic      pci2_i,   // Trusted pin level
  output logic      pci4_i,   // Pair-5 pin level
  output logic      f5_i      // Debug pin level
);
  // Board drives request only while device floats the pin
  assign pci0_i = pci0_oe ? pci0_o : req_a_n;
  assign pci1_i = pci1_oe ? pci1_o : req_b_n;
  // Strap resistors win while the device is not driving
  assign pci2_i = pci2_oe ? pci2_o : trusted_lvl;
  assign pci4_i = pci4_oe ? pci4_o : pair5_lvl;
  assign f5_i   = f5_oe ? f5_o : debug_lvl;
endmodule : cpfs_board_model

// [dv/cpfs_clock_pin_select_bench.sv]
`timescale 1ns/10ps
`define CHK(g,e) begin check_count++; if ((g)!==(e)) begin n_mismatch++; $display("BAD t=%0t got=%h exp=%h", $time, (g), (e)); end end
module cpfs_clock_pin_select_bench;
  import cpfs_pkg::*;
  logic core_clk = 1'b0, srst = 1'b1, pci_gen = 1'b0, stop_n = 1'b1, f5_last;
  logic [2:0] strap_lvl = 3'b101;
  logic req_a_n = 1'b1, req_b_n = 1'b1;
  cpfs_reg_req_t reg_req = '0;
  logic [7:0] rd_addr = 8'h00, rdata;
  logic p0i, p0o, p0e, p1i, p1o, p1e, p2i, p2o, p2e, p3o, p4i, p4o, p4e, f5i, f5o, f5e;
  logic [CPFS_PAIR_W-1:0] run;
  cpfs_straps_t straps;
  int n_mismatch = 0, check_count = 0, tog;

  always #5 core_clk = ~core_clk;
  always @(posedge core_clk) pci_gen <= ~pci_gen;

  cpfs_clock_pin_select i_cpfs_clock_pin_select (.core_clk(core_clk), .srst(srst),
    .reg_req(reg_req), .reg_rd_addr(rd_addr), .reg_rdata(rdata), .pci_clk_gen(pci_gen),
    .pci_stop_n(stop_n), .pci0_i(p0i), .pci0_o(p0o), .pci0_oe(p0e), .pci1_i(p1i),
    .pci1_o(p1o), .pci1_oe(p1e), .pci2_i(p2i), .pci2_o(p2o), .pci2_oe(p2e), .pci3_o(p3o),
    .pci4_i(p4i), .pci4_o(p4o), .pci4_oe(p4e), .debug_strap_i(f5i),
    .free_running_pci_clk(f5o), .free_running_oe(f5e), .ref_diff_pair_run(run),
    .straps(straps));

  cpfs_board_model i_cpfs_board_model (.trusted_lvl(strap_lvl[2]),
    .pair5_lvl(strap_lvl[1]), .debug_lvl(strap_lvl[0]),
    .pci0_o(p0o), .pci0_oe(p0e), .pci1_o(p1o),
    .pci1_oe(p1e), .pci2_o(p2o), .pci2_oe(p2e), .pci4_o(p4o), .pci4_oe(p4e), .f5_o(f5o),
    .f5_oe(f5e), .req_a_n(req_a_n), .req_b_n(req_b_n), .pci0_i(p0i), .pci1_i(p1i),
    .pci2_i(p2i), .pci4_i(p4i), .f5_i(f5i));

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk) reg_req <= '{wr_en: 1'b1, addr: a, wdata: d};
    @(posedge core_clk) reg_req.wr_en <= 1'b0;
    repeat (2) @(posedge core_clk);
    #1;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge core_clk) rd_addr <= a;
    @(posedge core_clk);
    #1;
    `CHK(rdata, e)
  endtask : rd

  task automatic pins(input logic a, input logic b);
    @(posedge core_clk) begin
      req_a_n <= a;
      req_b_n <= b;
    end
    repeat (3) @(posedge core_clk);
    #1;
  endtask : pins

  task automatic t_reset;
    `CHK(straps, 3'b101)
    `CHK(p0e, 1'b1)
    `CHK({p2e, p4e, f5e}, 3'b111)
    rd(CPFS_OUT_EN_OFS, 8'hFF);
    rd(CPFS_REQ_CFG_OFS, 8'h00);
    rd(8'h07, 8'h00);
  endtask : t_reset

  task automatic t_req_a;
    wr(CPFS_OUT_EN_OFS, 8'hFE);
    `CHK({p0e, p1e}, 2'b01)
    wr(CPFS_REQ_CFG_OFS, 8'h80);
    pins(1'b1, 1'b1);
    `CHK(run, 5'b11110)
    pins(1'b0, 1'b1);
    `CHK(run, 5'b11111)
    wr(CPFS_REQ_CFG_OFS, 8'hC0);
    pins(1'b1, 1'b1);
    `CHK(run, 5'b11011)
    rd(CPFS_REQ_CFG_OFS, 8'hC0);
  endtask : t_req_a

  task automatic t_req_b;
    wr(CPFS_OUT_EN_OFS, 8'hFC);
    `CHK(p1e, 1'b0)
    wr(CPFS_REQ_CFG_OFS, 8'h20);
    `CHK(run, 5'b11101)
    wr(CPFS_REQ_CFG_OFS, 8'h30);
    `CHK(run, 5'b01111)
    pins(1'b1, 1'b0);
    `CHK(run, 5'b11111)
    pins(1'b1, 1'b1);
    wr(CPFS_REQ_CFG_OFS, 8'h00);
    `CHK(run, 5'b11111)
  endtask : t_req_b

  task automatic t_stop;
    @(posedge core_clk) stop_n <= 1'b0;
    repeat (4) @(posedge core_clk);
    #1;
    tog = 0;
    repeat (8) begin
      f5_last = f5o;
      @(posedge core_clk);
      #1;
      tog += (f5o !== f5_last) ? 1 : 0;
      `CHK({p0o, p1o, p2o, p3o, p4o}, 5'h00)
    end
    `CHK(tog, 8)
    `CHK(f5o, ~pci_gen)
    @(posedge core_clk) stop_n <= 1'b1;
    repeat (4) @(posedge core_clk);
    #1;
    `CHK({p0o, p1o, p2o, p3o, p4o}, {5{~pci_gen}})
    `CHK(straps, 3'b101)
  endtask : t_stop

  task automatic t_repower;
    @(posedge core_clk) begin
      srst      <= 1'b1;
      strap_lvl <= 3'b010;
      stop_n    <= 1'b0;
    end
    repeat (2) @(posedge core_clk);
    srst <= 1'b0;
    repeat (3) @(posedge core_clk);
    #1;
    `CHK(straps, 3'b010)
    `CHK({p0e, p1e, p2e, p4e, f5e}, 5'h1F)
    `CHK({p0o, p1o, p2o, p3o, p4o}, {5{~pci_gen}})
    rd(CPFS_OUT_EN_OFS, 8'hFF);
    `CHK(p3o, ~pci_gen)
    @(posedge core_clk) stop_n <= 1'b1;
  endtask : t_repower

  task automatic tally_and_finish;
    $display("mismatches=%0d checks=%0d", n_mismatch, check_count);
    if (n_mismatch == 0 && check_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : tally_and_finish

  initial begin
    repeat (2) @(posedge core_clk);
    srst <= 1'b0;
    repeat (3) @(posedge core_clk);
    #1;
    t_reset();
    t_req_a();
    t_req_b();
    t_stop();
    t_repower();
    tally_and_finish();
  end

  initial begin
    #20000;
    n_mismatch++;
    tally_and_finish();
  end
endmodule : cpfs_clock_pin_select_bench
